// [core/dsos_pkg.sv]
// types shared by the status output selector
package dsos_pkg;

  // raw status conditions produced elsewhere in the driver
  typedef struct packed {
    logic       at_target_speed;
    logic       winding_energised;
    logic       standstill_current_reduced;
    logic       homing_done;
    logic       preset_done;
    logic       coordinate_established;
    logic       electrical_origin_enabled;
    logic       represet_needed;
    logic       user_origin_stored;
    logic       factory_origin_stored;
    logic       wrap_overflow_event;
    logic       forward_soft_limit_hit;
    logic       reverse_soft_limit_hit;
    logic       once_per_rev_pulse;
    logic       wrap_enabled;
    logic       at_wrap_origin;
    logic       step_72_pulse;
    logic       opdata_zone_inside;
    logic [7:0] zone_window;
    logic       main_power_on;
    logic       brake_released;
    logic       regenerating;
    logic       hw_torque_off_input_one;
    logic       hw_torque_off_input_two;
    logic       position_report_output;
    logic       pulse_request_ready;
    logic       current_limiting_active;
    logic       speed_limiting_active;
    logic       internal_oscillator_running;
  } dsos_cond_s;

  // configuration of one user logic output
  typedef struct packed {
    logic [5:0] sel_a;
    logic [5:0] sel_b;
    logic       use_or;
  } dsos_user_cfg_s;

  // selector state
  typedef struct packed {
    logic [3:0] out_r;
    logic       wrap_toggle_r;
    logic       user_a_r;
    logic       user_b_r;
  } dsos_state_s;

endpackage

// [core/dsos_regs.svh]
// assignment codes, sizes and reset values for the status output selector
`ifndef DSOS_REGS_SVH
`define DSOS_REGS_SVH

// ----------------------------------------------------------------
// assignment codes
// ----------------------------------------------------------------
`define DSOS_CODE_OFF        8'h80
`define DSOS_CODE_AT_SPEED   8'h8D
`define DSOS_CODE_ENERGISED  8'h8E
`define DSOS_CODE_CUTBACK    8'h8F
`define DSOS_CODE_HOME_END   8'h90
`define DSOS_CODE_COORD_SET  8'h91
`define DSOS_CODE_ELEC_ORG   8'h92
`define DSOS_CODE_REPRESET   8'h95
`define DSOS_CODE_USER_ORG   8'h96
`define DSOS_CODE_FACT_ORG   8'h97
`define DSOS_CODE_WRAP_OVF   8'h98
`define DSOS_CODE_FW_LIMIT   8'h99
`define DSOS_CODE_RV_LIMIT   8'h9A
`define DSOS_CODE_REV_PULSE  8'h9B
`define DSOS_CODE_WRAP_ORG   8'h9C
`define DSOS_CODE_STEP_72    8'h9D
`define DSOS_CODE_OPDATA_ZN  8'h9F
`define DSOS_CODE_ZONE_BASE  8'hA0
`define DSOS_CODE_ZONE_LAST  8'hA7
`define DSOS_CODE_MAIN_PWR   8'hA8
`define DSOS_CODE_BRAKE_REL  8'hA9
`define DSOS_CODE_REGEN      8'hAA
`define DSOS_CODE_TO_BOTH    8'hAC
`define DSOS_CODE_TO_ANY     8'hAD
`define DSOS_CODE_POS_REPORT 8'hB0
`define DSOS_CODE_PLS_READY  8'hB1
`define DSOS_CODE_USER_A     8'hB4
`define DSOS_CODE_USER_B     8'hB5
`define DSOS_CODE_CUR_LIMIT  8'hC0
`define DSOS_CODE_SPD_LIMIT  8'hC1
`define DSOS_CODE_OSC_RUN    8'hC4

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define DSOS_ZONE_IDX_W      3
`define DSOS_NUM_OUT         4
`define DSOS_USR_SEL_W       6
`define DSOS_OUT_RST         1'b0

`endif

// [core/dsos_selector.sv]
// status output function selector
`timescale 1ns/1ps
`default_nettype none
`include "dsos_regs.svh"

module dsos_selector
(
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic                   clk_en,
  // internal status conditions
  input  wire dsos_pkg::dsos_cond_s   cond,
  // assignment code per output
  input  wire logic [7:0]             assign_code [`DSOS_NUM_OUT],
  // user logic output setup
  input  wire dsos_pkg::dsos_user_cfg_s user_cfg_a,
  input  wire dsos_pkg::dsos_user_cfg_s user_cfg_b,
  // selected outputs to the host
  output var  logic [`DSOS_NUM_OUT-1:0] status_out,
  // user logic results
  output var  logic                   user_logic_output_a,
  output var  logic                   user_logic_output_b
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dsos_pkg::dsos_state_s st_r;   // all registered state
  dsos_pkg::dsos_state_s st_nxt; // next state
  logic [63:0]           src_vec; // conditions indexed for user logic

  // flat vector of conditions the user logic gates can pick from;
  // the user outputs themselves are excluded to avoid a loop
  always_comb
  begin
    src_vec     = '0;
    src_vec[0]  = cond.at_target_speed;
    src_vec[1]  = cond.winding_energised;
    src_vec[2]  = cond.standstill_current_reduced;
    src_vec[3]  = cond.homing_done | cond.preset_done;
    src_vec[4]  = cond.coordinate_established;
    src_vec[5]  = cond.electrical_origin_enabled;
    src_vec[6]  = cond.represet_needed;
    src_vec[7]  = cond.user_origin_stored;
    src_vec[8]  = cond.factory_origin_stored;
    src_vec[9]  = st_r.wrap_toggle_r;
    src_vec[10] = cond.forward_soft_limit_hit;
    src_vec[11] = cond.reverse_soft_limit_hit;
    src_vec[12] = cond.once_per_rev_pulse;
    src_vec[13] = cond.wrap_enabled & cond.at_wrap_origin;
    src_vec[14] = cond.step_72_pulse;
    src_vec[15] = cond.opdata_zone_inside;
    src_vec[23:16] = cond.zone_window;
    src_vec[24] = cond.brake_released;
    src_vec[25] = cond.regenerating;
    src_vec[26] = ~cond.hw_torque_off_input_one & ~cond.hw_torque_off_input_two;
    src_vec[27] = ~cond.hw_torque_off_input_one | ~cond.hw_torque_off_input_two;
    src_vec[28] = cond.current_limiting_active;
    src_vec[29] = cond.speed_limiting_active;
    src_vec[30] = cond.internal_oscillator_running;
    src_vec[31] = cond.main_power_on;
  end

  // one output's decode; wrap and user levels are passed in so the
  // decode never reads the next-state copy that it helps to fill
  function automatic logic pick(input logic [7:0] code,
                                input logic       wrap_lvl,  // toggle level after this edge
                                input logic       usr_a,     // gate a after this edge
                                input logic       usr_b);    // gate b after this edge
    logic v;
    v = 1'b0;
    unique case (code)
      `DSOS_CODE_OFF:        v = 1'b0;
      `DSOS_CODE_AT_SPEED:   v = cond.at_target_speed;
      `DSOS_CODE_ENERGISED:  v = cond.winding_energised;
      `DSOS_CODE_CUTBACK:    v = cond.standstill_current_reduced;
      `DSOS_CODE_HOME_END:   v = cond.homing_done | cond.preset_done;
      `DSOS_CODE_COORD_SET:  v = cond.coordinate_established;
      `DSOS_CODE_ELEC_ORG:   v = cond.electrical_origin_enabled;
      `DSOS_CODE_REPRESET:   v = cond.represet_needed;
      `DSOS_CODE_USER_ORG:   v = cond.user_origin_stored;
      `DSOS_CODE_FACT_ORG:   v = cond.factory_origin_stored;
      `DSOS_CODE_WRAP_OVF:   v = wrap_lvl;
      `DSOS_CODE_FW_LIMIT:   v = cond.forward_soft_limit_hit;
      `DSOS_CODE_RV_LIMIT:   v = cond.reverse_soft_limit_hit;
      `DSOS_CODE_REV_PULSE:  v = cond.once_per_rev_pulse;
      `DSOS_CODE_WRAP_ORG:   v = cond.wrap_enabled & cond.at_wrap_origin;
      `DSOS_CODE_STEP_72:    v = cond.step_72_pulse;
      `DSOS_CODE_OPDATA_ZN:  v = cond.opdata_zone_inside;
      `DSOS_CODE_MAIN_PWR:   v = cond.main_power_on;
      `DSOS_CODE_BRAKE_REL:  v = cond.brake_released;
      `DSOS_CODE_REGEN:      v = cond.regenerating;
      `DSOS_CODE_TO_BOTH:    v = src_vec[26];
      `DSOS_CODE_TO_ANY:     v = src_vec[27];
      `DSOS_CODE_POS_REPORT: v = cond.position_report_output;
      `DSOS_CODE_PLS_READY:  v = cond.pulse_request_ready;
      `DSOS_CODE_USER_A:     v = usr_a;
      `DSOS_CODE_USER_B:     v = usr_b;
      `DSOS_CODE_CUR_LIMIT:  v = cond.current_limiting_active;
      `DSOS_CODE_SPD_LIMIT:  v = cond.speed_limiting_active;
      `DSOS_CODE_OSC_RUN:    v = cond.internal_oscillator_running;
      default:
      begin
        // zone windows share one range; other codes stay inactive
        if (code >= `DSOS_CODE_ZONE_BASE && code <= `DSOS_CODE_ZONE_LAST)
          v = cond.zone_window[code[`DSOS_ZONE_IDX_W-1:0]];
        else
          v = 1'b0;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // user gates and wrap toggle first, then every output re-decoded
  // each enabled cycle so a code change takes effect at the next enabled edge
  always_comb
  begin
    st_nxt = st_r;
    if (cond.wrap_overflow_event)
      st_nxt.wrap_toggle_r = ~st_r.wrap_toggle_r;
    st_nxt.user_a_r = user_cfg_a.use_or
      ? (src_vec[user_cfg_a.sel_a] | src_vec[user_cfg_a.sel_b])
      : (src_vec[user_cfg_a.sel_a] & src_vec[user_cfg_a.sel_b]);
    st_nxt.user_b_r = user_cfg_b.use_or
      ? (src_vec[user_cfg_b.sel_a] | src_vec[user_cfg_b.sel_b])
      : (src_vec[user_cfg_b.sel_a] & src_vec[user_cfg_b.sel_b]);
    for (int i = 0; i < `DSOS_NUM_OUT; i++)
      st_nxt.out_r[i] = pick(assign_code[i], st_nxt.wrap_toggle_r,
                             st_nxt.user_a_r, st_nxt.user_b_r);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // clock enable freezes everything, toggle level included
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

  // outputs straight from flip-flops
  assign status_out          = st_r.out_r;
  assign user_logic_output_a = st_r.user_a_r;
  assign user_logic_output_b = st_r.user_b_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  off_code_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_OFF) |=> !status_out[0])
    else $error("code off drove output high");

  speed_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_AT_SPEED)
      |=> status_out[0] == $past(cond.at_target_speed))
    else $error("speed output mismatch");

  home_end_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_HOME_END && cond.preset_done)
      |=> status_out[0])
    else $error("preset not shown");

  wrap_toggle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && cond.wrap_overflow_event)
      |=> st_r.wrap_toggle_r != $past(st_r.wrap_toggle_r))
    else $error("wrap toggle missed");

  wrap_origin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_WRAP_ORG && !cond.wrap_enabled)
      |=> !status_out[0])
    else $error("wrap origin without wrap");

  zone_pick_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_ZONE_LAST)
      |=> status_out[1] == $past(cond.zone_window[7]))
    else $error("zone window mismatch");

  torque_both_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_TO_BOTH && cond.hw_torque_off_input_one)
      |=> !status_out[0])
    else $error("both-off wrong");

  torque_any_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_TO_ANY && !cond.hw_torque_off_input_two)
      |=> status_out[0])
    else $error("any-off wrong");

  user_or_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && user_cfg_a.use_or && src_vec[user_cfg_a.sel_a])
      |=> user_logic_output_a)
    else $error("user or wrong");

  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !clk_en |=> $stable(status_out))
    else $error("frozen output changed");

  // remaining codes except main power and user gate b, spread over all four lines so that every
  // output's decode path is watched by at least one check
  energised_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_ENERGISED)
      |=> status_out[1] == $past(cond.winding_energised))
    else $error("energised output mismatch");

  cutback_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_CUTBACK)
      |=> status_out[2] == $past(cond.standstill_current_reduced))
    else $error("cutback output mismatch");

  coord_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_COORD_SET)
      |=> status_out[3] == $past(cond.coordinate_established))
    else $error("coordinate output mismatch");

  elec_origin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_ELEC_ORG)
      |=> status_out[2] == $past(cond.electrical_origin_enabled))
    else $error("electrical origin mismatch");

  represet_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_REPRESET)
      |=> status_out[1] == $past(cond.represet_needed))
    else $error("represet output mismatch");

  user_origin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_USER_ORG)
      |=> status_out[0] == $past(cond.user_origin_stored))
    else $error("user origin mismatch");

  factory_origin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_FACT_ORG)
      |=> status_out[3] == $past(cond.factory_origin_stored))
    else $error("factory origin mismatch");

  wrap_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_WRAP_OVF && cond.wrap_overflow_event)
      |=> status_out[2] != $past(st_r.wrap_toggle_r))
    else $error("wrap output not toggled");

  fw_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_FW_LIMIT)
      |=> status_out[1] == $past(cond.forward_soft_limit_hit))
    else $error("forward limit mismatch");

  rv_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_RV_LIMIT)
      |=> status_out[3] == $past(cond.reverse_soft_limit_hit))
    else $error("reverse limit mismatch");

  rev_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_REV_PULSE)
      |=> status_out[2] == $past(cond.once_per_rev_pulse))
    else $error("revolution pulse mismatch");

  step_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_STEP_72)
      |=> status_out[3] == $past(cond.step_72_pulse))
    else $error("step pulse mismatch");

  opdata_zone_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_OPDATA_ZN)
      |=> status_out[1] == $past(cond.opdata_zone_inside))
    else $error("operation zone mismatch");

  zone_first_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_ZONE_BASE)
      |=> status_out[2] == $past(cond.zone_window[0]))
    else $error("first zone mismatch");

  brake_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_BRAKE_REL)
      |=> status_out[3] == $past(cond.brake_released))
    else $error("brake output mismatch");

  regen_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_REGEN)
      |=> status_out[0] == $past(cond.regenerating))
    else $error("regeneration output mismatch");

  pos_report_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_POS_REPORT)
      |=> status_out[1] == $past(cond.position_report_output))
    else $error("position report mismatch");

  pulse_ready_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[2] == `DSOS_CODE_PLS_READY)
      |=> status_out[2] == $past(cond.pulse_request_ready))
    else $error("pulse ready mismatch");

  user_and_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !user_cfg_b.use_or && !src_vec[user_cfg_b.sel_b])
      |=> !user_logic_output_b)
    else $error("user and wrong");

  user_route_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_USER_A)
      |=> status_out[0] == user_logic_output_a)
    else $error("user gate a not routed");

  cur_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[3] == `DSOS_CODE_CUR_LIMIT)
      |=> status_out[3] == $past(cond.current_limiting_active))
    else $error("current limit mismatch");

  spd_limit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[0] == `DSOS_CODE_SPD_LIMIT)
      |=> status_out[0] == $past(cond.speed_limiting_active))
    else $error("speed limit mismatch");

  osc_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && assign_code[1] == `DSOS_CODE_OSC_RUN)
      |=> status_out[1] == $past(cond.internal_oscillator_running))
    else $error("oscillator output mismatch");

endmodule
`default_nettype wire

// [sim/dsos_host_model.sv]
// host controller model that scans the selector outputs
`timescale 1ns/1ps
`default_nettype none
`include "dsos_regs.svh"

module dsos_host_model
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // lines read from the driver
  input  wire logic [`DSOS_NUM_OUT-1:0] status_out,
  input  wire logic [7:0]               assign_code [`DSOS_NUM_OUT],
  // pulse requests issued so far
  output var  int                       proceed_count
);
  // ----------------------------------------------------------------
  // scan loop
  // ----------------------------------------------------------------
  // a request goes out only once the ready line reads high
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
      proceed_count <= 0;
    else
      foreach (status_out[i])
        if (assign_code[i] == `DSOS_CODE_PLS_READY && status_out[i] === 1'b1)
          proceed_count <= proceed_count + 1;
endmodule
`default_nettype wire

// [sim/test_driver_status_output_selector.sv]
// self-checking bench for the status output selector
`timescale 1ns/1ps
`default_nettype none
`include "dsos_regs.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("mismatch at %0t: %s", $time, m); end end

module test_driver_status_output_selector;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                     ref_clk = 1'b0;  // 4 ns period
  logic                     resetn  = 1'b0;  // async, active low
  logic                     clk_en  = 1'b0;  // edge enable
  dsos_pkg::dsos_cond_s     cond    = '0;    // random conditions
  logic [7:0]               assign_code [`DSOS_NUM_OUT] = '{default: 8'h00};
  dsos_pkg::dsos_user_cfg_s cfg_a   = '0;    // user gate setups
  dsos_pkg::dsos_user_cfg_s cfg_b   = '0;
  logic [`DSOS_NUM_OUT-1:0] status_out;      // design outputs
  logic                     user_a;
  logic                     user_b;
  int                       proceed_n;       // host requests
  int                       miscompares = 0;
  int                       check_count = 0;
  bit                       tog = 0;         // model wrap toggle
  bit                       ea = 0;          // model gate results
  bit                       eb = 0;
  bit [`DSOS_NUM_OUT-1:0]   exp_out = '0;    // model outputs
  bit                       rdy = 0;         // a ready line seen this edge
  int                       exp_proceed = 0; // model host requests
  // listed codes plus a few unused ones that must read 0
  int codes[$] = '{128, 141, 142, 143, 144, 145, 146, 149, 150, 151, 152, 153, 154,
    155, 156, 157, 159, 160, 161, 162, 163, 164, 165, 166, 167, 168, 169, 170, 172,
    173, 176, 177, 180, 181, 192, 193, 196, 147, 148, 158, 171, 200, 0};

  initial forever #2 ref_clk = ~ref_clk;

  dsos_selector i_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
    .cond(cond), .assign_code(assign_code), .user_cfg_a(cfg_a), .user_cfg_b(cfg_b),
    .status_out(status_out), .user_logic_output_a(user_a), .user_logic_output_b(user_b));

  dsos_host_model i_host (.ref_clk(ref_clk), .resetn(resetn), .status_out(status_out),
    .assign_code(assign_code), .proceed_count(proceed_n));

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  // source vector shared by the user gates
  function automatic bit src(int idx, dsos_pkg::dsos_cond_s c, bit t);
    bit [31:0] v;
    v = {c.main_power_on, c.internal_oscillator_running, c.speed_limiting_active,
      c.current_limiting_active,
      !c.hw_torque_off_input_one || !c.hw_torque_off_input_two,
      !c.hw_torque_off_input_one && !c.hw_torque_off_input_two,
      c.regenerating, c.brake_released, c.zone_window, c.opdata_zone_inside,
      c.step_72_pulse, c.wrap_enabled && c.at_wrap_origin, c.once_per_rev_pulse,
      c.reverse_soft_limit_hit, c.forward_soft_limit_hit, t, c.factory_origin_stored,
      c.user_origin_stored, c.represet_needed, c.electrical_origin_enabled,
      c.coordinate_established, c.homing_done || c.preset_done,
      c.standstill_current_reduced, c.winding_energised, c.at_target_speed};
    return idx < 32 ? v[idx] : 1'b0;
  endfunction

  // gates see the toggle level from before this edge
  function automatic bit gate(dsos_pkg::dsos_user_cfg_s g, dsos_pkg::dsos_cond_s c, bit t);
    bit a;
    bit b;
    a = src(int'(g.sel_a), c, t);
    b = src(int'(g.sel_b), c, t);
    return g.use_or ? a | b : a & b;
  endfunction

  // expected level of one output for a given code
  function automatic bit sel(int code, dsos_pkg::dsos_cond_s c, bit t, bit a, bit b);
    int ix;
    case (code)
      141, 142, 143, 144, 145, 146: ix = code - 141;
      149, 150, 151, 152, 153, 154, 155, 156, 157: ix = code - 143;
      159, 160, 161, 162, 163, 164, 165, 166, 167: ix = code - 144;
      169, 170: ix = code - 145;
      172, 173: ix = code - 146;
      192, 193: ix = code - 164;
      196: ix = 30;
      168: ix = 31;
      176: return c.position_report_output;
      177: return c.pulse_request_ready;
      180: return a;
      181: return b;
      default: return 1'b0;
    endcase
    return src(ix, c, t);
  endfunction

  // model registers follow the design's enabled edges
  always @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      tog = 0;
      ea = 0;
      eb = 0;
      exp_out = '0;
      exp_proceed = 0;
    end
    else
    begin
      // the host sees the lines as they stood before this edge
      rdy = 1'b0;
      foreach (exp_out[i])
        if (assign_code[i] == `DSOS_CODE_PLS_READY && exp_out[i])
          rdy = 1'b1;
      if (rdy)
        exp_proceed++;
      if (clk_en)
      begin
        ea = gate(cfg_a, cond, tog);
        eb = gate(cfg_b, cond, tog);
        tog ^= cond.wrap_overflow_event;
        foreach (exp_out[i])
          exp_out[i] = sel(int'(assign_code[i]), cond, tog, ea, eb);
      end
    end

  // compare on the falling edge, when all updates have landed
  always @(negedge ref_clk)
  begin
    `CHK(status_out, exp_out, "status outputs")
    `CHK(user_a, ea, "user gate a")
    `CHK(user_b, eb, "user gate b")
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  // gate selects span the whole index range, toggle source included
  function automatic dsos_pkg::dsos_user_cfg_s rcfg();
    dsos_pkg::dsos_user_cfg_s r;
    r = 13'($urandom);
    return r;
  endfunction

  task automatic drive();
    logic [63:0] rv;
    rv = {$urandom, $urandom};
    cond <= rv[$bits(dsos_pkg::dsos_cond_s)-1:0];
    clk_en <= ($urandom % 8) != 0;
    foreach (assign_code[i])
      assign_code[i] <= 8'(codes[$urandom % codes.size()]);
    cfg_a <= rcfg();
    cfg_b <= rcfg();
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // random traffic with a second reset in mid-run
  initial
  begin
    void'($urandom(17270));
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int n = 0; n < 6000; n++)
    begin
      @(posedge ref_clk);
      drive();
      if (n == 3000)
        resetn <= 1'b0;
      if (n == 3004)
        resetn <= 1'b1;
    end
    // let the last edge's updates land before reading the host count
    @(negedge ref_clk);
    `CHK(proceed_n, exp_proceed, "host requests")
    summarize();
  end
endmodule
`default_nettype wire
